//--- dv/rscp_host_model.sv
// host serial port model: 8n1 sender and receiver on two lines
`default_nettype none
module rscp_host_model #(
  parameter int BIT_CLKS = 2160
) (
  input  wire logic clk_sys,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_q[$];
  logic [7:0] sh;

  initial line_out = 1'b1;

  // one frame: start, data lsb first, one stop, no parity
  // stop is normally high; a low stop provokes a framing error
  task automatic send_char(input logic [7:0] d,
                           input logic       stop);
    for (int i = 0; i < 10; i++) begin
      line_out = (i == 0) ? 1'b0 : (i == 9) ? stop : d[i-1];
      repeat (BIT_CLKS) @(posedge clk_sys);
      #1;
    end
    if (!stop) line_out = 1'b1;
  endtask

  // mid-bit sampling; a bad stop drops the char so the bench sees a gap
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      sh[i] = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk_sys);
    if (line_in === 1'b1) got_q.push_back(sh);
  end
endmodule
`default_nettype wire

//--- dv/rscp_port_monitor.sv
// assertion checker bound onto the remote serial command port
`default_nettype none
module rscp_port_monitor (
  input wire logic                    clk_sys,
  input wire logic                    reset,
  input wire logic [1:0]              term_sel,
  input wire logic                    serial_select,
  input wire logic                    tx_pin,
  input wire logic                    tx_valid,
  input wire logic                    tx_ready,
  input wire rscp_pkg::rscp_rx_char_s rx_char,
  input wire logic                    rx_valid,
  input wire logic                    rx_ready,
  input wire logic                    rx_overrun,
  input wire logic                    port_active
);
  // shortest legal low stretch: a partial start bit of 15 ticks at 115200
  localparam int MIN_LOW = 2025;
  int low_run;
  int next_low_run;

  // length of the current low stretch on the transmit line
  always_comb next_low_run = tx_pin ? 0 : low_run + 1;
  always_ff @(posedge clk_sys) low_run <= reset ? 0 : next_low_run;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_reset_idle_out: assert property ($past(reset) |-> tx_pin && !tx_ready
    && !rx_valid && !rx_overrun && !port_active)
    else $error("outputs not idle after reset");
  a_take_starts_bit: assert property (tx_valid && tx_ready |=>
    !tx_pin && !tx_ready) else $error("no start bit after accept");
  a_low_bit_len: assert property ($rose(tx_pin) |-> low_run >= MIN_LOW)
    else $error("low bit too short for the rate");
  a_ready_line_idle: assert property (tx_ready |-> tx_pin)
    else $error("transmit line not idle while ready");
  a_unsel_no_ready: assert property (!serial_select ##1 !serial_select
    |=> !tx_ready) else $error("ready while port deselected");
  a_select_tracks: assert property (!$past(reset) |->
    port_active == $past(serial_select)) else $error("port_active lags");
  a_rx_char_hold: assert property (rx_valid && !rx_ready |=> rx_valid
    && $stable(rx_char)) else $error("received char dropped");
  a_eol_cr_only: assert property (rx_valid && term_sel == rscp_pkg::TERM_CR
    |-> rx_char.eol == (rx_char.data == rscp_pkg::CHAR_CR))
    else $error("line end mark wrong in CR mode");

  c_tx_take: cover property (tx_valid && tx_ready);
  c_rx_eol: cover property (rx_valid && rx_char.eol);
  c_deselect: cover property ($fell(port_active));
  c_frame_err: cover property (rx_valid && rx_char.frame_err);
endmodule
bind rscp_port rscp_port_monitor i_rscp_port_monitor (.clk_sys(clk_sys),
  .reset(reset), .term_sel(term_sel), .serial_select(serial_select),
  .tx_pin(tx_pin), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_char(rx_char), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_overrun(rx_overrun), .port_active(port_active));
`default_nettype wire

//--- dv/rscp_port_tb.sv
// self-checking bench for the remote serial command port
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  n_errors++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module rscp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT_CLKS = 16 * rscp_pkg::DIV_115200;
  logic                    clk_sys = 1'b0;
  logic                    reset;
  logic [2:0]              baud_sel;
  logic [1:0]              term_sel;
  logic                    serial_select;
  logic                    rx_pin;
  logic                    tx_pin;
  logic [7:0]              tx_data;
  logic                    tx_valid;
  logic                    tx_ready;
  rscp_pkg::rscp_rx_char_s rx_char;
  logic                    rx_valid;
  logic                    rx_ready;
  logic                    rx_overrun;
  logic                    port_active;
  int                      n_errors = 0;
  int                      cmp_count = 0;

  always #2 clk_sys = ~clk_sys;

  // full frames only at the fastest rate; the slower 38400 rate is timed by start bit
  rscp_port i_rscp_port (.clk_sys(clk_sys), .reset(reset),
    .baud_sel(baud_sel), .term_sel(term_sel),
    .serial_select(serial_select), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_char(rx_char), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_overrun(rx_overrun), .port_active(port_active));
  rscp_host_model #(.BIT_CLKS(BIT_CLKS)) i_rscp_host_model (
    .clk_sys(clk_sys), .line_in(tx_pin), .line_out(rx_pin));

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // a limit used up counts against the run and ends it
  task automatic give_up(input int i);
    if (i >= 30000) begin
      n_errors++;
      stop_test();
    end
  endtask

  task automatic tx_send(input logic [7:0] d);
    int i;
    tx_data = d;
    tx_valid = 1'b1;
    for (i = 0; i < 30000 && tx_ready !== 1'b1; i++) step(1);
    give_up(i);
    step(1);
    tx_valid = 1'b0;
    step(1);
  endtask

  // holds off rx_ready a few cycles so the output must stand
  task automatic rx_get(input logic [7:0] d, input logic eol,
                        input logic       ferr);
    int i;
    for (i = 0; i < 30000 && rx_valid !== 1'b1; i++) step(1);
    give_up(i);
    step(4);
    `CHK("rx_valid", 1'b1, rx_valid)
    `CHK("rx_data", d, rx_char.data)
    `CHK("rx_eol", eol, rx_char.eol)
    `CHK("rx_frame", ferr, rx_char.frame_err)
    rx_ready = 1'b1;
    step(1);
    rx_ready = 1'b0;
    step(1);
  endtask

  task automatic host_wait(input int n);
    int i;
    for (i = 0; i < 30000 && i_rscp_host_model.got_q.size() < n; i++) step(1);
    give_up(i);
  endtask

  task automatic sc_reset();
    `CHK("tx_pin", 1'b1, tx_pin)
    `CHK("tx_ready", 1'b0, tx_ready)
    `CHK("port_active", 1'b0, port_active)
    `CHK("rx_overrun", 1'b0, rx_overrun)
    `CHK("rx_valid_rst", 1'b0, rx_valid)
  endtask

  task automatic sc_select();
    serial_select = 1'b0;
    step(3);
    `CHK("tx_ready_off", 1'b0, tx_ready)
    `CHK("port_off", 1'b0, port_active)
    serial_select = 1'b1;
    step(3);
    `CHK("tx_ready_on", 1'b1, tx_ready)
    `CHK("port_on", 1'b1, port_active)
  endtask

  // both directions in the same frame time
  task automatic sc_duplex();
    term_sel = rscp_pkg::TERM_CR;
    fork
      i_rscp_host_model.send_char(rscp_pkg::CHAR_CR, 1'b1);
      tx_send(8'hA5);
    join
    host_wait(1);
    `CHK("host_rx0", 8'hA5, i_rscp_host_model.got_q[0])
    rx_get(rscp_pkg::CHAR_CR, 1'b1, 1'b0);
  endtask

  // back-to-back frames; only the LF closes the line
  task automatic sc_crlf();
    term_sel = rscp_pkg::TERM_CRLF;
    fork
      begin
        i_rscp_host_model.send_char(rscp_pkg::CHAR_CR, 1'b1);
        i_rscp_host_model.send_char(rscp_pkg::CHAR_LF, 1'b1);
      end
      begin
        tx_send(8'h3C);
        tx_send(8'hC3);
      end
    join
    host_wait(3);
    `CHK("host_rx1", 8'h3C, i_rscp_host_model.got_q[1])
    `CHK("host_rx2", 8'hC3, i_rscp_host_model.got_q[2])
    rx_get(rscp_pkg::CHAR_CR, 1'b0, 1'b0);
    rx_get(rscp_pkg::CHAR_LF, 1'b1, 1'b0);
  endtask

  // LF mode and a low stop bit: char still delivered, error marked
  task automatic sc_frame();
    term_sel = rscp_pkg::TERM_LF;
    i_rscp_host_model.send_char(rscp_pkg::CHAR_LF, 1'b0);
    rx_get(rscp_pkg::CHAR_LF, 1'b1, 1'b1);
    // wait a quarter bit; the receiver drops its false start before the rate changes
    step(BIT_CLKS / 4);
  endtask

  // slower rate timed by its start bit, then a reset cuts the frame
  task automatic sc_rate();
    int   n;
    logic len_ok;
    baud_sel = rscp_pkg::SEL_38400;
    step(2);
    tx_send(8'h55);
    for (n = 0; n < 30000 && tx_pin === 1'b0; n++) step(1);
    give_up(n);
    // start bit is 15 partial to 16 whole ticks of the chosen divider
    len_ok = (n >= 15 * rscp_pkg::DIV_38400) &&
             (n < 16 * rscp_pkg::DIV_38400);
    `CHK("start_len_ok", 1'b1, len_ok)
    reset = 1'b1;
    baud_sel = rscp_pkg::SEL_115200;
    step(12);
    sc_reset();
    reset = 1'b0;
    step(2);
    `CHK("tx_ready_rst", 1'b1, tx_ready)
    `CHK("port_rst", 1'b1, port_active)
  endtask

  initial begin
    reset = 1'b1;
    baud_sel = rscp_pkg::SEL_115200;
    term_sel = rscp_pkg::TERM_CR;
    serial_select = 1'b1;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    step(12);
    sc_reset();
    reset = 1'b0;
    step(2);
    sc_select();
    sc_duplex();
    sc_crlf();
    sc_frame();
    sc_rate();
    stop_test();
  end
endmodule
`default_nettype wire

//--- rtl/rscp_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`default_nettype none
module rscp_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and fill level update
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

//--- rtl/rscp_pkg.sv
// package for the remote serial command port: timing, enums and carriers
`default_nettype none
package rscp_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned BAUD_1200     = 1200;
  localparam int unsigned BAUD_9600     = 9600;
  localparam int unsigned BAUD_19200    = 19200;
  localparam int unsigned BAUD_38400    = 38400;
  localparam int unsigned BAUD_115200   = 115200;
  // oversampling ticks per bit; divider counts clk_sys per tick
  localparam int unsigned OVERSAMPLE    = 16;
  localparam int unsigned DIV_1200      = CLK_HZ / (BAUD_1200 * OVERSAMPLE);
  localparam int unsigned DIV_9600      = CLK_HZ / (BAUD_9600 * OVERSAMPLE);
  localparam int unsigned DIV_19200     = CLK_HZ / (BAUD_19200 * OVERSAMPLE);
  localparam int unsigned DIV_38400     = CLK_HZ / (BAUD_38400 * OVERSAMPLE);
  localparam int unsigned DIV_115200    = CLK_HZ / (BAUD_115200 * OVERSAMPLE);
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam logic [7:0]  CHAR_CR       = 8'h0D;
  localparam logic [7:0]  CHAR_LF       = 8'h0A;
  localparam logic        LINE_IDLE     = 1'b1;

  // baud selection codes
  localparam logic [2:0] SEL_1200   = 3'h0;
  localparam logic [2:0] SEL_9600   = 3'h1;
  localparam logic [2:0] SEL_19200  = 3'h2;
  localparam logic [2:0] SEL_38400  = 3'h3;
  localparam logic [2:0] SEL_115200 = 3'h4;

  // line terminator selection codes
  localparam logic [1:0] TERM_CR   = 2'h0;
  localparam logic [1:0] TERM_LF   = 2'h1;
  localparam logic [1:0] TERM_CRLF = 2'h2;

  typedef enum logic [3:0] {
    BIT_IDLE  = 4'b0001,
    BIT_START = 4'b0010,
    BIT_DATA  = 4'b0100,
    BIT_STOP  = 4'b1000
  } rscp_bit_e;

  // received character with line-end and framing marks
  typedef struct packed {
    logic       eol;
    logic       frame_err;
    logic [7:0] data;
  } rscp_rx_char_s;
endpackage
`default_nettype wire

//--- rtl/rscp_port.sv
// remote serial command port: 8n1 uart with line terminator detection
// Notes on behaviour
// - full duplex, separate lines, start bit, 8 data bits, 1 stop, no parity
// - bit rate selectable 1200/9600/19200/38400/115200; both ends must agree
// - only transmit, receive and ground; no modem or handshake lines
// - serial path works only when selected; USB paths then stay idle; a frame already started on tx_pin still completes
// - characters carry text commands and responses of the shared command set
`default_nettype none
module rscp_port (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic [2:0]             baud_sel,
  input  wire logic [1:0]             term_sel,
  input  wire logic                   serial_select,
  input  wire logic                   rx_pin,
  output logic                        tx_pin,
  input  wire logic [7:0]             tx_data,
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  output rscp_pkg::rscp_rx_char_s     rx_char,
  output logic                        rx_valid,
  input  wire logic                   rx_ready,
  output logic                        rx_overrun,
  output logic                        port_active
);
  // divider per selected rate, ticks at 16x bit rate
  logic [15:0] div_limit;
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic        tick;

  always_comb begin
    case (baud_sel)
      rscp_pkg::SEL_1200:   div_limit = 16'(rscp_pkg::DIV_1200 - 1);
      rscp_pkg::SEL_9600:   div_limit = 16'(rscp_pkg::DIV_9600 - 1);
      rscp_pkg::SEL_19200:  div_limit = 16'(rscp_pkg::DIV_19200 - 1);
      rscp_pkg::SEL_38400:  div_limit = 16'(rscp_pkg::DIV_38400 - 1);
      rscp_pkg::SEL_115200: div_limit = 16'(rscp_pkg::DIV_115200 - 1);
      default:              div_limit = 16'(rscp_pkg::DIV_9600 - 1);
    endcase
    next_div_cnt = (div_cnt >= div_limit) ? 16'h0000 : div_cnt + 16'h0001;
  end
  assign tick = (div_cnt >= div_limit);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // three-stage synchroniser on the receive pin
  logic [2:0] rx_sync;
  logic       rx_level;
  logic       next_rx_level;
  always_comb begin
    next_rx_level = rx_level;
    if (rx_sync[2] == rx_sync[1]) begin
      next_rx_level = rx_sync[1];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_sync  <= 3'h7;
      rx_level <= rscp_pkg::LINE_IDLE;
    end else begin
      rx_sync  <= {rx_sync[1:0], rx_pin};
      rx_level <= next_rx_level;
    end
  end

  // receiver: samples mid-bit on 16x ticks
  rscp_pkg::rscp_bit_e rx_st, next_rx_st;
  logic [3:0] rx_tk, next_rx_tk;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic       rx_cr_seen, next_rx_cr_seen;
  rscp_pkg::rscp_rx_char_s rx_word, next_rx_word;
  logic       rx_push, next_rx_push;
  logic       rx_in_ready;
  logic       next_rx_overrun;

  always_comb begin
    next_rx_st      = rx_st;
    next_rx_tk      = rx_tk;
    next_rx_bit     = rx_bit;
    next_rx_sh      = rx_sh;
    next_rx_cr_seen = rx_cr_seen;
    next_rx_word    = rx_word;
    next_rx_push    = 1'b0;
    next_rx_overrun = rx_overrun;
    if (!serial_select) begin
      next_rx_st = rscp_pkg::BIT_IDLE;
      next_rx_cr_seen = 1'b0;
    end else if (tick) begin
      next_rx_tk = rx_tk + 4'h1;
      case (rx_st)
        rscp_pkg::BIT_IDLE: begin
          next_rx_tk = 4'h0;
          if (!rx_level) begin
            next_rx_st = rscp_pkg::BIT_START;
          end
        end
        rscp_pkg::BIT_START: begin
          // half a bit in: a glitch back to idle is rejected
          if (rx_tk == 4'h7) begin
            next_rx_tk = 4'h0;
            next_rx_bit = 3'h0;
            next_rx_st = rx_level ? rscp_pkg::BIT_IDLE : rscp_pkg::BIT_DATA;
          end
        end
        rscp_pkg::BIT_DATA: begin
          if (rx_tk == 4'hF) begin
            next_rx_sh = {rx_level, rx_sh[7:1]};
            next_rx_bit = rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              next_rx_st = rscp_pkg::BIT_STOP;
            end
          end
        end
        rscp_pkg::BIT_STOP: begin
          if (rx_tk == 4'hF) begin
            // no parity bit: stop follows the eighth data bit
            next_rx_st = rscp_pkg::BIT_IDLE;
            next_rx_word.data = rx_sh;
            next_rx_word.frame_err = !rx_level;
            next_rx_word.eol = 1'b0;
            case (term_sel)
              rscp_pkg::TERM_CR:
                next_rx_word.eol = (rx_sh == rscp_pkg::CHAR_CR);
              rscp_pkg::TERM_LF:
                next_rx_word.eol = (rx_sh == rscp_pkg::CHAR_LF);
              rscp_pkg::TERM_CRLF:
                next_rx_word.eol = rx_cr_seen &&
                                   (rx_sh == rscp_pkg::CHAR_LF);
              default: next_rx_word.eol = 1'b0;
            endcase
            next_rx_cr_seen = (rx_sh == rscp_pkg::CHAR_CR);
            // no handshake line: a full buffer can only drop and flag
            if (rx_in_ready) begin
              next_rx_push = 1'b1;
            end else begin
              next_rx_overrun = 1'b1;
            end
          end
        end
        default: next_rx_st = rscp_pkg::BIT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_st      <= rscp_pkg::BIT_IDLE;
      rx_tk      <= 4'h0;
      rx_bit     <= 3'h0;
      rx_sh      <= 8'h00;
      rx_cr_seen <= 1'b0;
      rx_word    <= '0;
      rx_push    <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      rx_st      <= next_rx_st;
      rx_tk      <= next_rx_tk;
      rx_bit     <= next_rx_bit;
      rx_sh      <= next_rx_sh;
      rx_cr_seen <= next_rx_cr_seen;
      rx_word    <= next_rx_word;
      rx_push    <= next_rx_push;
      rx_overrun <= next_rx_overrun;
    end
  end

  // received characters queue for the command parser
  rscp_pkg::rscp_rx_char_s fifo_out;
  logic                    fifo_valid;
  logic                    take;
  rscp_fifo #(
    .WIDTH ($bits(rscp_pkg::rscp_rx_char_s)),
    .DEPTH (rscp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (rx_word),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (take)
  );

  // registered output stage so outputs come from flip-flops
  rscp_pkg::rscp_rx_char_s next_rx_char;
  logic                    next_rx_valid;
  always_comb begin
    take          = fifo_valid && (!rx_valid || rx_ready);
    next_rx_valid = rx_valid && !rx_ready;
    next_rx_char  = rx_char;
    if (take) begin
      next_rx_valid = 1'b1;
      next_rx_char  = fifo_out;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_valid <= 1'b0;
      rx_char  <= '0;
    end else begin
      rx_valid <= next_rx_valid;
      rx_char  <= next_rx_char;
    end
  end

  // transmitter: 10-bit frame, one bit per 16 ticks
  rscp_pkg::rscp_bit_e tx_st, next_tx_st;
  logic [3:0] tx_tk, next_tx_tk;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_sh, next_tx_sh;
  logic       next_tx_pin, next_tx_ready, next_active;

  always_comb begin
    next_tx_st    = tx_st;
    next_tx_tk    = tx_tk;
    next_tx_bit   = tx_bit;
    next_tx_sh    = tx_sh;
    next_tx_pin   = tx_pin;
    next_tx_ready = 1'b0;
    next_active   = serial_select;
    case (tx_st)
      rscp_pkg::BIT_IDLE: begin
        next_tx_pin   = rscp_pkg::LINE_IDLE;
        next_tx_ready = serial_select;
        if (tx_valid && tx_ready) begin
          next_tx_sh    = tx_data;
          next_tx_st    = rscp_pkg::BIT_START;
          next_tx_tk    = 4'h0;
          next_tx_ready = 1'b0;
          next_tx_pin   = 1'b0;
        end
      end
      rscp_pkg::BIT_START: begin
        if (tick) begin
          next_tx_tk = tx_tk + 4'h1;
          if (tx_tk == 4'hF) begin
            next_tx_st  = rscp_pkg::BIT_DATA;
            next_tx_bit = 3'h0;
            next_tx_pin = tx_sh[0];
          end
        end
      end
      rscp_pkg::BIT_DATA: begin
        if (tick) begin
          next_tx_tk = tx_tk + 4'h1;
          if (tx_tk == 4'hF) begin
            next_tx_sh  = {1'b0, tx_sh[7:1]};
            next_tx_bit = tx_bit + 3'h1;
            next_tx_pin = tx_sh[1];
            if (tx_bit == 3'h7) begin
              next_tx_st  = rscp_pkg::BIT_STOP;
              next_tx_pin = 1'b1;
            end
          end
        end
      end
      rscp_pkg::BIT_STOP: begin
        if (tick) begin
          next_tx_tk = tx_tk + 4'h1;
          if (tx_tk == 4'hF) begin
            next_tx_st = rscp_pkg::BIT_IDLE;
          end
        end
      end
      default: next_tx_st = rscp_pkg::BIT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_st       <= rscp_pkg::BIT_IDLE;
      tx_tk       <= 4'h0;
      tx_bit      <= 3'h0;
      tx_sh       <= 8'h00;
      tx_pin      <= rscp_pkg::LINE_IDLE;
      tx_ready    <= 1'b0;
      port_active <= 1'b0;
    end else begin
      tx_st       <= next_tx_st;
      tx_tk       <= next_tx_tk;
      tx_bit      <= next_tx_bit;
      tx_sh       <= next_tx_sh;
      tx_pin      <= next_tx_pin;
      tx_ready    <= next_tx_ready;
      port_active <= next_active;
    end
  end
endmodule
`default_nettype wire
